// ### bench/csa_user_model.sv
// Purpose: surrounding user logic that feeds the slice its carry and clear pin
// Assumes: requests from the bench are taken on the rising edge of pclk
// Notes:   registered, so pin and carry change just after an edge only
module csa_user_model (
  input  wire logic pclk,
  input  wire logic want_clr,
  input  wire logic want_cin,
  output logic      clr_drv_n,
  output logic      carry_in
);
  // idle values before the first edge, pin released high
  initial begin
    clr_drv_n = 1'b1;
    carry_in  = 1'b0;
  end

  // user logic decides when the clear pin is let go
  always @(posedge pclk) begin
    clr_drv_n <= ~want_clr;
    carry_in  <= want_cin;
  end
endmodule

// ### bench/tb_carry_select_adder_slice.sv
// Purpose: self-checking bench for the ten-cell carry-select slice
// Assumes: zero-wait APB slave, default build options
// Notes:   expectations are worked out here from operand, control and carry-in values
module tb_carry_select_adder_slice;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        clr_o;
  logic        clr_oe_n;
  logic        clr_drv_n;
  logic        pin_n;
  logic        carry_in;
  logic        carry_out;
  logic [10:0] cell_q;
  logic        want_clr = 1'b0;
  logic        want_cin = 1'b0;
  int          errors = 0;
  int          num_checks = 0;
  // pin level: the slice wins only while it drives
  assign pin_n = (clr_oe_n === 1'b0) ? clr_o : clr_drv_n;
  always #10 pclk = ~pclk;
  csa_slice dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_clear_n(pin_n), .chip_clear_o(clr_o), .chip_clear_oe_n(clr_oe_n),
    .carry_in(carry_in), .carry_out(carry_out), .cell_q(cell_q));
  csa_user_model partner (.pclk(pclk), .want_clr(want_clr), .want_cin(want_cin),
    .clr_drv_n(clr_drv_n), .carry_in(carry_in));
  // compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one apb transfer, idle cycle first so strobes never toggle twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // wait as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(name, r, exp);
    check("pslverr", {31'h0, e}, 32'h0000_0000);
  endtask
  // reference sum: cells below start pass data1, chain adds the rest
  function automatic logic [10:0] ref_sum(input logic [9:0] a, input logic [9:0] b,
                                          input logic [11:0] c, input logic ci);
    logic [3:0]  s;
    logic [9:0]  bb;
    logic [10:0] hi;
    s = c[11:8] - 4'h1;
    bb = c[1] ? ~b : b;
    hi = ({1'b0, a} >> s) + ({1'b0, bb} >> s) + {10'h0, (c[3] ? ci : c[1])};
    if (!c[0]) return {1'b0, a};
    return (hi << s) | {1'b0, a & ~(10'h3ff << s)};
  endfunction
  // live sum through the bypass path, plus the cascade carry pin
  task automatic arith_case(input logic [9:0] a, input logic [9:0] b, input logic [11:0] c, input logic ci);
    want_cin <= ci;
    wr(csa_pkg::OFS_OPA, {22'h0, a});
    wr(csa_pkg::OFS_OPB, {22'h0, b});
    wr(csa_pkg::OFS_CTRL, {20'h0, c});
    rd_chk("result", csa_pkg::OFS_RESULT, {21'h0, ref_sum(a, b, c, ci)});
    check("carry_out", {31'h0, carry_out}, 32'(ref_sum(a, b, c, ci) >> 10));
  endtask
  task automatic test_reset;
    check("cell_q", {21'h0, cell_q}, 32'h0000_0000);
    check("clr_oe_n", {31'h0, clr_oe_n}, 32'h0000_0001);
    check("clr_o", {31'h0, clr_o}, 32'h0000_0000);
    rd_chk("ctrl", csa_pkg::OFS_CTRL, 32'h0000_0100);
  endtask
  task automatic test_arith;
    arith_case(10'h3ff, 10'h001, 12'h105, 1'b0);
    arith_case(10'h155, 10'h0ab, 12'h105, 1'b0);
    arith_case(10'h100, 10'h001, 12'h107, 1'b0);
    arith_case(10'h001, 10'h002, 12'h107, 1'b0);
    arith_case(10'h3ff, 10'h009, 12'h405, 1'b0);
    arith_case(10'h200, 10'h3ff, 12'ha07, 1'b0);
    arith_case(10'h1ff, 10'h200, 12'h10d, 1'b1);
    arith_case(10'h2a5, 10'h0f0, 12'h104, 1'b0);
  endtask
  // registered result lands one edge after capture
  task automatic test_registered;
    wr(csa_pkg::OFS_OPA, 32'h0000_02f0);
    wr(csa_pkg::OFS_OPB, 32'h0000_01f0);
    wr(csa_pkg::OFS_CTRL, 32'h0000_0121);
    repeat (2) @(posedge pclk);
    check("cell_q", {21'h0, cell_q}, 32'h0000_04e0);
    rd_chk("result", csa_pkg::OFS_RESULT, 32'h0000_04e0);
    wr(csa_pkg::OFS_CTRL, 32'h0000_0100);
  endtask
  // group controls: clear beats preset, two clears, sync load and clear
  task automatic test_controls;
    logic [31:0] act[6] = '{32'h0000_0004, 32'h0000_0005, 32'h0000_0006,
                            32'h0000_ffe6, 32'h0000_0010, 32'h0000_0008};
    logic [10:0] exq[6] = '{11'h7ff, 11'h000, 11'h7ff, 11'h000, 11'h2a5, 11'h000};
    wr(csa_pkg::OFS_SLD, 32'h0000_02a5);
    for (int i = 0; i < 6; i++) begin
      wr(csa_pkg::OFS_ACTL, act[i]);
      repeat (3) @(posedge pclk);
      check("cell_q", {21'h0, cell_q}, {21'h0, exq[i]});
    end
  endtask
  // pin low clears at once, release lets the held preset back in
  task automatic test_chip_clear;
    wr(csa_pkg::OFS_ACTL, 32'h0000_0004);
    want_clr <= 1'b1;
    repeat (2) @(posedge pclk);
    check("cell_q", {21'h0, cell_q}, 32'h0000_0000);
    rd_chk("status", csa_pkg::OFS_STATUS, 32'h0000_0001);
    want_clr <= 1'b0;
    repeat (5) @(posedge pclk);
    check("cell_q", {21'h0, cell_q}, 32'h0000_07ff);
    wr(csa_pkg::OFS_ACTL, 32'h0000_0000);
  endtask
  task automatic test_bus_error;
    logic [31:0] r;
    logic e;
    apb(1'b0, 8'h1c, 32'h0000_0000, r, e);
    check("unmapped", {r[30:0], e}, 32'h0000_0001);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_reset();
    test_arith();
    test_registered();
    test_controls();
    test_chip_clear();
    test_bus_error();
    report_and_stop();
  end
  // watchdog, far beyond the roughly 180 cycles the run needs
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    report_and_stop();
  end
endmodule

// ### src/csa_cell.sv
// Purpose: one logic cell in dynamic arithmetic mode
// Assumes: carry pair arrives from the next lower cell
// Notes:   purely combinational, no state
module csa_cell (
  input  wire logic active,
  input  wire logic data1,
  input  wire logic data2,
  input  wire logic cin0,
  input  wire logic cin1,
  input  wire logic sel,
  output logic      cout0,
  output logic      cout1,
  output logic      sum
);
  logic gen;                                      // both bits set
  logic prop;                                     // either bit set
  logic sum0;                                     // sum assuming chain 0
  logic sum1;                                     // sum assuming chain 1

  // both sums and both carries computed side by side
  always_comb begin
    gen  = data1 & data2;
    prop = data1 | data2;
    sum0 = data1 ^ data2 ^ cin0;                  // RULE1
    sum1 = data1 ^ data2 ^ cin1;                  // RULE1
    if (active) begin
      cout0 = cin0 ? prop : gen;                  // RULE6
      cout1 = cin1 ? prop : gen;                  // RULE6
      sum   = sel ? sum1 : sum0;                  // RULE18
    end else begin
      // outside the chain the pair passes untouched
      cout0 = cin0;                               // RULE21
      cout1 = cin1;                               // RULE21
      sum   = data1;
    end
  end
endmodule

// ### src/csa_out_reg.sv
// Purpose: output register of one logic cell
// Assumes: all async controls come from flip-flops, so they do not glitch
// Notes:   preset is an async load of a constant one
module csa_out_reg #(
  parameter logic PWR_HIGH = 1'b0                 // power-up level of this register
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic chip_clr_n,
  input  wire logic aclr,
  input  wire logic apre,
  input  wire logic sclr,
  input  wire logic sload,
  input  wire logic ld_data,
  input  wire logic en,
  input  wire logic d,
  output logic      q
);
  csa_pkg::csa_oreg_t st_ff;                      // registered state
  csa_pkg::csa_oreg_t nxt_st;                     // next state

  // synchronous controls: clear beats load beats capture
  always_comb begin
    nxt_st = st_ff;
    if (sclr) begin
      nxt_st.q = 1'b0;                            // RULE19
    end else if (sload) begin
      nxt_st.q = ld_data;                         // RULE19
    end else if (en) begin
      nxt_st.q = d;
    end
  end

  // chip clear outranks reset so a held pin keeps the register low
  always_ff @(posedge pclk or negedge chip_clr_n or negedge presetn or posedge aclr or posedge apre) begin
    if (!chip_clr_n) begin
      st_ff <= '{q: 1'b0};                        // RULE13
    end else if (!presetn) begin
      st_ff <= '{q: PWR_HIGH};                    // RULE16
    end else if (aclr) begin
      st_ff <= '{q: 1'b0};                        // RULE11
    end else if (apre) begin
      st_ff <= '{q: 1'b1};                        // RULE10
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.q;
endmodule

// ### src/csa_pkg.sv
// Purpose: shared constants and carriers for the carry-select adder slice
// Assumes: one group of ten logic cells behind an APB slave
// Notes:   byte offsets, field layouts and the control word reset value live here
package csa_pkg;
  localparam int NCELL = 10;                      // logic cells per cell group
  localparam int HALF  = 5;                       // group carry regenerated after this cell
  localparam int NREG  = NCELL + 1;               // cell registers plus the carry-out cell

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFS_CTRL   = 8'h00;      // mode and chain control
  localparam logic [7:0] OFS_OPA    = 8'h04;      // data1 operand, one bit per cell
  localparam logic [7:0] OFS_OPB    = 8'h08;      // data2 operand, one bit per cell
  localparam logic [7:0] OFS_SLD    = 8'h0C;      // synchronous load data
  localparam logic [7:0] OFS_ACTL   = 8'h10;      // group-wide register controls
  localparam logic [7:0] OFS_RESULT = 8'h14;      // read only: cell outputs
  localparam logic [7:0] OFS_STATUS = 8'h18;      // read only: clear pin state

  localparam logic [3:0]  START_RST = 4'h1;       // chain starts at cell one after reset
  localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

  // control word, lsb first from arith
  typedef struct packed {
    logic [3:0] start;                            // first chain cell, 1..10
    logic       gpio_drive;                       // drive the clear pin as an output when the clear option is off
    logic       gpio_out;                         // level driven in that case
    logic       run;                              // registers capture every clock
    logic       accum;                            // data1 taken from the own register
    logic       casc_en;                          // carry-in from the group to the left
    logic       bypass;                           // result read without the register
    logic       sub;                              // add/subtract select, 1 = subtract
    logic       arith;                            // dynamic arithmetic mode
  } csa_ctrl_t;

  // group-wide register controls, lsb first from aclr0
  typedef struct packed {
    logic [NREG-1:0] clr_sel;                     // per register: 0 = clear 0, 1 = clear 1
    logic            sload;                       // synchronous load
    logic            sclr;                        // synchronous clear
    logic            apre;                        // the single group preset
    logic            aclr1;                       // second group clear
    logic            aclr0;                       // first group clear
  } csa_actl_t;

  localparam int CTRL_W = $bits(csa_ctrl_t);
  localparam int ACTL_W = $bits(csa_actl_t);
  localparam csa_ctrl_t CTRL_RST = '{start: START_RST, default: 1'b0};

  typedef struct packed {
    logic q;                                      // the cell's output register
  } csa_oreg_t;

  typedef struct packed {
    csa_ctrl_t       ctrl;
    csa_actl_t       actl;
    logic [NCELL-1:0] opa;
    logic [NCELL-1:0] opb;
    logic [NREG-1:0] sld;
    logic [NREG-1:0] clr_vec;                     // resolved clear per register
    logic            pre;                         // registered preset
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            gpio_o;
    logic            gpio_oe_n;
    logic            pin_q;                       // sampled pin level
  } csa_state_t;
endpackage

// ### src/csa_slice.sv
// Purpose: ten-cell carry-select adder group with output registers and clear control
// Assumes: APB slave with zero wait states; pins synchronous to pclk
// Notes:   carry_out is combinational so groups can be chained in one row
//
// Behaviour
// RULE1: each cell computes both carry-in cases
// RULE2: carry pair feeds forward to next cell
// RULE3: chain may start at any cell
// RULE4: group carry-in selects; regenerated at cells 5, 10
// RULE5: sum routed out, register optional
// RULE6: chain carry selects its forwarded carry-out
// RULE7: final carry-out lands in a cell register
// RULE8: wider sums cascade carry to next group
// RULE9: no carry cascade across row ends
// RULE10: preset is async load of one
// RULE11: clear wins over simultaneous preset
// RULE12: two group clears, one group preset
// RULE13: chip clear resets all, overrides all; the code clears only the cell registers, the bus state keeps its value
// RULE14: pin held low keeps clears asserted
// RULE15: option off makes pin plain I/O
// RULE16: registers power up low unless configured
// RULE17: subtract inverts B, forces carry-in one
// RULE18: sum is data1 plus data2 plus chain carry
// RULE19: sync clear and load are group-wide
// RULE20: chip clear async assert, clocked release
// RULE21: unused cells pass the carry pair
module csa_slice #(
  parameter logic [csa_pkg::NREG-1:0] POWERUP_HIGH  = '0,    // per register power-up one
  parameter logic                     CHIP_CLEAR_EN = 1'b1,  // pre-build option for the clear pin
  parameter logic                     ROW_START     = 1'b0   // group sits at the left end of a row
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     chip_clear_n,
  output logic                          chip_clear_o,
  output logic                          chip_clear_oe_n,
  input  wire logic                     carry_in,
  output logic                          carry_out,
  output logic [csa_pkg::NREG-1:0]      cell_q
);
  localparam int N = csa_pkg::NCELL;
  localparam int H = csa_pkg::HALF;
  localparam int R = csa_pkg::NREG;

  csa_pkg::csa_state_t st_ff;                     // all bus-side state
  csa_pkg::csa_state_t nxt_st;                    // next value of it
  logic [1:0]          clr_sync_ff;               // chip clear release stages
  logic                pin_rst_n;                 // asserts the clear asynchronously
  logic                chip_run;                  // registers released from chip clear

  logic [N-1:0]        d1;                        // data1 per cell
  logic [N-1:0]        d2;                        // data2 per cell after inversion
  logic [N-1:0]        ci0;                       // chain 0 carry into each cell
  logic [N-1:0]        ci1;                       // chain 1 carry into each cell
  logic [N-1:0]        co0;                       // chain 0 carry out of each cell
  logic [N-1:0]        co1;                       // chain 1 carry out of each cell
  logic [N-1:0]        act;                       // cell belongs to the chain
  logic [N-1:0]        sum;                       // selected sums
  logic [R-1:0]        reg_d;                     // register inputs, carry cell on top
  logic [3:0]          start_idx;                 // zero-based first chain cell
  logic                casc_ok;                   // cascade input usable
  logic                cin_chain;                 // group carry-in
  logic                sel_lo;                    // select for cells 1..5
  logic                lo_cout;                   // group carry made at cell 5
  logic                sel_hi;                    // select for cells 6..10
  logic                cout_comb;                 // group carry made at cell 10

  // out-of-range starts clamp to the ends of the group
  function automatic logic [3:0] start_of(input logic [3:0] s);
    if (s == 4'h0) begin
      start_of = 4'h0;
    end else if (s > 4'(N)) begin
      start_of = 4'(N - 1);
    end else begin
      start_of = s - 4'h1;
    end
  endfunction

  // only aligned, mapped words answer without error
  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      csa_pkg::OFS_CTRL, csa_pkg::OFS_OPA, csa_pkg::OFS_OPB, csa_pkg::OFS_SLD,
      csa_pkg::OFS_ACTL, csa_pkg::OFS_RESULT, csa_pkg::OFS_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  // chip clear: pin asserts at once, release waits two edges
  assign pin_rst_n = chip_clear_n | ~CHIP_CLEAR_EN;               // RULE15
  always_ff @(posedge pclk or negedge pin_rst_n or negedge presetn) begin
    if (!pin_rst_n) begin
      clr_sync_ff <= 2'b00;                       // RULE14
    end else if (!presetn) begin
      clr_sync_ff <= 2'b11;
    end else begin
      clr_sync_ff <= {clr_sync_ff[0], 1'b1};      // RULE20
    end
  end
  assign chip_run = clr_sync_ff[1];

  // operand steering
  assign d1        = st_ff.ctrl.accum ? cell_q[N-1:0] : st_ff.opa;   // RULE5
  assign d2        = st_ff.opb ^ {N{st_ff.ctrl.arith & st_ff.ctrl.sub}}; // RULE17
  assign start_idx = start_of(st_ff.ctrl.start);
  // a row-start group never takes a carry from the row before
  assign casc_ok   = st_ff.ctrl.casc_en & ~ROW_START;              // RULE9
  // cascaded groups take the left carry; the lsb group forces one on subtract
  assign cin_chain = casc_ok ? carry_in : (st_ff.ctrl.arith & st_ff.ctrl.sub); // RULE8 RULE17

  // group-level selects only sit at cells 5 and 10
  assign sel_lo    = cin_chain;                                    // RULE4
  assign lo_cout   = sel_lo ? co1[H-1] : co0[H-1];                 // RULE4
  assign sel_hi    = (start_idx >= 4'(H)) ? cin_chain : lo_cout;   // RULE4
  assign cout_comb = st_ff.ctrl.arith & (sel_hi ? co1[N-1] : co0[N-1]); // RULE4

  genvar g;
  for (g = 0; g < N; g++) begin : g_cell
    // each half starts a fresh pair, so the long path is only at the selects
    if (g == 0 || g == H) begin : g_head
      assign ci0[g] = 1'b0;
      assign ci1[g] = 1'b1;
    end else begin : g_link
      assign ci0[g] = co0[g-1];                   // RULE2
      assign ci1[g] = co1[g-1];                   // RULE2
    end
    assign act[g] = st_ff.ctrl.arith & (4'(g) >= start_idx);      // RULE3
    csa_cell u_cell (
      .active (act[g]),
      .data1  (d1[g]),
      .data2  (d2[g]),
      .cin0   (ci0[g]),
      .cin1   (ci1[g]),
      .sel    ((g < H) ? sel_lo : sel_hi),
      .cout0  (co0[g]),
      .cout1  (co1[g]),
      .sum    (sum[g])
    );
  end

  // the carry-out cell takes the group carry like any sum bit
  assign reg_d = {cout_comb, sum};                                // RULE7

  for (g = 0; g < R; g++) begin : g_reg
    csa_out_reg #(.PWR_HIGH(POWERUP_HIGH[g])) u_reg (
      .pclk       (pclk),
      .presetn    (presetn),
      .chip_clr_n (chip_run),
      .aclr       (st_ff.clr_vec[g]),
      .apre       (st_ff.pre),
      .sclr       (st_ff.actl.sclr),
      .sload      (st_ff.actl.sload),
      .ld_data    (st_ff.sld[g]),
      .en         (st_ff.ctrl.run),
      .d          (reg_d[g]),
      .q          (cell_q[g])
    );
  end

  assign carry_out = cout_comb;                                   // RULE8

  // bus decode, control resolution and pin mirror
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.pready = 1'b1;
    // read word and error are prepared in the setup cycle
    if (psel && !penable) begin
      nxt_st.pslverr = ~addr_ok(paddr);
      case (paddr)
        csa_pkg::OFS_CTRL:   nxt_st.prdata = {(32 - csa_pkg::CTRL_W)'(0), st_ff.ctrl};
        csa_pkg::OFS_OPA:    nxt_st.prdata = {(32 - N)'(0), st_ff.opa};
        csa_pkg::OFS_OPB:    nxt_st.prdata = {(32 - N)'(0), st_ff.opb};
        csa_pkg::OFS_SLD:    nxt_st.prdata = {(32 - R)'(0), st_ff.sld};
        csa_pkg::OFS_ACTL:   nxt_st.prdata = {(32 - csa_pkg::ACTL_W)'(0), st_ff.actl};
        // bypass shows the live sum, else the held register
        csa_pkg::OFS_RESULT: nxt_st.prdata = {(32 - R)'(0), st_ff.ctrl.bypass ? reg_d : cell_q}; // RULE5
        csa_pkg::OFS_STATUS: nxt_st.prdata = {30'(0), st_ff.pin_q, ~chip_run};
        default:             nxt_st.prdata = csa_pkg::RD_ZERO;
      endcase
    end
    // writes land at the access edge; read-only and unmapped words ignore them
    if (psel && penable && pwrite && st_ff.pready) begin
      case (paddr)
        csa_pkg::OFS_CTRL: nxt_st.ctrl = csa_pkg::csa_ctrl_t'(pwdata[csa_pkg::CTRL_W-1:0]);
        csa_pkg::OFS_OPA:  nxt_st.opa  = pwdata[N-1:0];
        csa_pkg::OFS_OPB:  nxt_st.opb  = pwdata[N-1:0];
        csa_pkg::OFS_SLD:  nxt_st.sld  = pwdata[R-1:0];
        csa_pkg::OFS_ACTL: nxt_st.actl = csa_pkg::csa_actl_t'(pwdata[csa_pkg::ACTL_W-1:0]);
        default: ;
      endcase
    end
    // each register picks one of the two group clears
    for (int i = 0; i < R; i++) begin
      nxt_st.clr_vec[i] = st_ff.actl.clr_sel[i] ? st_ff.actl.aclr1 : st_ff.actl.aclr0; // RULE12
    end
    nxt_st.pre       = st_ff.actl.apre;                           // RULE12
    // pin is plain I/O only when the clear function is not built in
    nxt_st.gpio_oe_n = ~(~CHIP_CLEAR_EN & st_ff.ctrl.gpio_drive); // RULE15
    nxt_st.gpio_o    = st_ff.ctrl.gpio_out;
    nxt_st.pin_q     = chip_clear_n;
  end

  // bus state resets with presetn only; chip clear targets the cell registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{ctrl: csa_pkg::CTRL_RST, gpio_oe_n: 1'b1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata          = st_ff.prdata;
  assign pready          = st_ff.pready;
  assign pslverr         = st_ff.pslverr;
  assign chip_clear_o    = st_ff.gpio_o;
  assign chip_clear_oe_n = st_ff.gpio_oe_n;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [R-1:0] exp_full;                         // reference sum from cell one
  logic [7:0]   exp_mid;                          // reference sum from cell four
  assign exp_full = {1'b0, d1} + {1'b0, d2} + R'(cin_chain);
  assign exp_mid  = {1'b0, d1[N-1:3]} + {1'b0, d2[N-1:3]} + 8'(cin_chain);

  sequence s_clr_pre;
    st_ff.pre && (st_ff.clr_vec != '0) && chip_run;
  endsequence
  sequence s_pre_only;
    st_ff.pre && (st_ff.clr_vec == '0) && chip_run && presetn;
  endsequence

  a_sum_exact: assert property (st_ff.ctrl.arith && start_idx == 4'h0 |-> reg_d == exp_full) // RULE18
    else $error("full group sum differs from reference");
  a_start_mid: assert property (st_ff.ctrl.arith && start_idx == 4'h3 // RULE3
                                |-> sum[2:0] == d1[2:0] && reg_d[R-1:3] == exp_mid)
    else $error("chain starting at cell four is wrong");
  a_sub_lsb: assert property (st_ff.ctrl.arith && st_ff.ctrl.sub && !casc_ok |-> cin_chain) // RULE17
    else $error("subtract did not force carry-in");
  a_row_block: assert property (ROW_START |-> cin_chain == (st_ff.ctrl.arith && st_ff.ctrl.sub)) // RULE9
    else $error("carry crossed a row end");
  a_clr_wins: assert property (s_clr_pre |=> (cell_q & $past(st_ff.clr_vec)) == '0) // RULE11
    else $error("preset beat a clear");
  // a clear arriving one cycle later legally wipes the preset, so it must stay absent
  a_preset_one: assert property (s_pre_only ##1 s_pre_only |-> cell_q == '1) // RULE10
    else $error("preset did not load ones");
  a_sync_clear: assert property (st_ff.actl.sclr && !st_ff.actl.apre && !st_ff.pre && chip_run // RULE19
                                 && st_ff.clr_vec == '0 ##1 chip_run |-> cell_q == '0)
    else $error("synchronous clear missed a register");
  a_pin_hold: assert property (CHIP_CLEAR_EN && !chip_clear_n |-> !chip_run && cell_q == '0) // RULE14
    else $error("registers free while clear pin low");
  a_release_two: assert property ($rose(chip_run) |-> $past(chip_clear_n) && $past(chip_clear_n, 2)) // RULE20
    else $error("chip clear released too early");
  a_gpio_mode: assert property (!CHIP_CLEAR_EN |-> chip_run) // RULE15
    else $error("pin clears registers with option off");
  a_opa_write: assert property (psel && penable && pwrite && paddr == csa_pkg::OFS_OPA
                                |=> st_ff.opa == $past(pwdata[N-1:0]))
    else $error("operand write lost");
endmodule
